/* File: src/otr_clk_div.v */
/*
  Integer half-period divider for the reference/system clock.
  Assumes half_period is stable-ish; a change takes effect at the
  next toggle or at once if the count already passed it.
*/
`timescale 1ns/1ps
`default_nettype none

module otr_clk_div (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire [14:0] half_period,
  output wire        clk_out,
  output wire        bypass
);

  reg  [14:0] cnt_r;
  reg         tog_r;

  // Zero passes the source straight through
  assign bypass  = (half_period == 15'h0000);
  assign clk_out = bypass ? ref_clk : tog_r;

  // Toggle every half_period source clocks, ratio 2N
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_r <= 15'h0000;
      tog_r <= 1'b0;
    end else if (bypass) begin
      cnt_r <= 15'h0000;
    end else if (cnt_r >= half_period - 15'h0001) begin
      cnt_r <= 15'h0000;
      tog_r <= ~tog_r;
    end else begin
      cnt_r <= cnt_r + 15'h0001;
    end
  end

endmodule

`default_nettype wire

/* File: src/otr_regs.vh */
/*
  Register offsets, field positions, reset values and timing figures
  for the oscillator tune and reference divider block.
  Assumes a 32-bit APB with byte addresses and a 100 MHz ref_clk.
*/
`ifndef OTR_REGS_VH
`define OTR_REGS_VH

// Byte offsets of the four registers
`define OTR_ADDR_TUNE_CTRL   12'h000
`define OTR_ADDR_DCO_TUNE    12'h004
`define OTR_ADDR_DCO_CTRL    12'h008
`define OTR_ADDR_DIVISOR     12'h00C

// Tune control and DIGITAL_CONTROLLED_OSC control field positions
`define OTR_ST_EN_BIT        15
`define OTR_ST_IDLE_BIT      13
`define OTR_ST_REF_BIT       12
`define OTR_ST_LOCK_BIT      11
`define OTR_LOCK_POL_BIT     10
`define OTR_ST_OOR_BIT       9
`define OTR_OOR_POL_BIT      8
`define OTR_DCO_RUN_BIT      13
`define OTR_DCO_FSEL_LSB     8

// Writable bits and reset values
`define OTR_TUNE_WMASK       16'hB53F
`define OTR_TUNE_RST         16'h1000
`define OTR_DCO_TUNE_WMASK   16'h003F
`define OTR_DCO_CTRL_WMASK   16'h2F00
`define OTR_DCO_CTRL_RST     16'h0700
`define OTR_DIV_RST          15'h0001

// Timing figures and tolerances
`define OTR_CLK_MHZ          100
`define OTR_SOF_PERIOD_US    1000
`define OTR_SECONDARY_OSCILLATOR_HZ          32768
`define OTR_SECONDARY_OSCILLATOR_EDGES       32
`define OTR_LOCK_DIV         500
`define OTR_OOR_NUM          3
`define OTR_OOR_DEN          200
`define OTR_DEAD_DIV         1000

// DIGITAL_CONTROLLED_OSC step size in hundredths of a percent
`define OTR_DCO_STEP_BP      5'h0F
`define OTR_DCO_WIDE_BP      5'h1D

`endif

/* File: src/otr_top.v */
/*
  Oscillator tune and reference divider control: APB register file,
  RC self-tune loop control, DIGITAL_CONTROLLED_OSC tune/select outputs, divider setup.
  Assumes APB master on ref_clk; idle_mode, sleep_mode and sof_evt
  come from logic on ref_clk; secondary_oscillator_in is an asynchronous pin.
*/
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "otr_regs.vh"

module otr_top #(
  parameter [23:0] USB_EXP_CNT  = `OTR_SOF_PERIOD_US * `OTR_CLK_MHZ,
  parameter [23:0] SECONDARY_OSCILLATOR_EXP_CNT =
    (`OTR_CLK_MHZ * 1000000 / `OTR_SECONDARY_OSCILLATOR_HZ) * `OTR_SECONDARY_OSCILLATOR_EDGES
) (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        idle_mode,
  input  wire        sleep_mode,
  input  wire        sof_evt,
  input  wire        secondary_oscillator_in,
  output reg  [5:0]  rc_tuning_field,
  output reg         lock_irq,
  output reg         oor_irq,
  output reg  [5:0]  dco_tuning_field,
  output reg  [4:0]  dco_step_bp,
  output reg  [4:0]  dco_freq_mhz,
  output reg         dco_active,
  output wire        div_clk_out,
  output wire        div_bypass
);

  // Decoded register index, 4 means unmapped
  function [2:0] reg_index;
    input [11:0] addr;
    begin
      case (addr)
        `OTR_ADDR_TUNE_CTRL: reg_index = 3'h0;
        `OTR_ADDR_DCO_TUNE:  reg_index = 3'h1;
        `OTR_ADDR_DCO_CTRL:  reg_index = 3'h2;
        `OTR_ADDR_DIVISOR:   reg_index = 3'h3;
        default:             reg_index = 3'h4;
      endcase
    end
  endfunction

  // DIGITAL_CONTROLLED_OSC frequency select to MHz, reserved codes give 0
  // Codes 8 to 13 are never to be written; a 0 makes a stray write visible
  function [4:0] fsel_mhz;
    input [3:0] fsel;
    begin
      case (fsel)
        4'h0, 4'h1, 4'h2, 4'h3,
        4'h4, 4'h5, 4'h6, 4'h7: fsel_mhz = {1'b0, fsel} + 5'h01;
        4'hE:                   fsel_mhz = 5'h0F;
        4'hF:                   fsel_mhz = 5'h1E;
        default:                fsel_mhz = 5'h00;
      endcase
    end
  endfunction

  // Reset images as whole words; fields are sliced from them so that
  // no shifted word is silently narrowed into a short register
  localparam [15:0] TUNE_RST_W = `OTR_TUNE_RST;
  localparam [15:0] DCO_CTRL_W = `OTR_DCO_CTRL_RST;
  localparam [14:0] DIV_RST_W  = `OTR_DIV_RST;

  // Control state
  reg        st_en_r;
  reg        st_idle_stop_r;
  reg        st_ref_r;
  reg        lock_pol_r;
  reg        oor_pol_r;
  reg  [5:0] rc_tune_r;
  reg  [5:0] dco_tune_r;
  reg        dco_run_r;
  reg  [3:0] dco_fsel_r;
  reg [14:0] div_r;

  // Pin synchroniser for the secondary oscillator
  reg        secondary_oscillator_s1_r;
  reg        secondary_oscillator_s2_r;
  reg        secondary_oscillator_s3_r;
  reg        secondary_oscillator_lvl_r;
  reg  [4:0] secondary_oscillator_edges_r;
  reg        secondary_oscillator_meas_r;

  wire       lock_st;
  wire       oor_st;
  wire       step_up;
  wire       step_dn;
  wire       usb_lock;
  wire       usb_oor;
  wire       usb_up;
  wire       usb_dn;
  wire       secondary_oscillator_lock;
  wire       secondary_oscillator_oor;
  wire       secondary_oscillator_up;
  wire       secondary_oscillator_dn;
  wire       loop_run;
  wire       secondary_oscillator_rise;
  wire [2:0] sel;
  wire       wr_en;
  wire       wr_tune;
  wire       setup;
  wire [15:0] wdat;
  wire [15:0] tune_rd;
  wire [15:0] dco_tune_rd;
  wire [15:0] dco_ctrl_rd;
  wire [15:0] div_rd;

  // Zero-wait slave; an unmapped offset answers with an error
  assign sel     = reg_index(paddr);
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite & (sel != 3'h4);
  assign wdat    = pwdata[15:0];
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (sel == 3'h4);

  // Tune control is written from two places; one strobe keeps them in step
  assign wr_tune = wr_en & (sel == 3'h0);

  // The loop runs only when enabled and not parked by Idle
  assign loop_run = st_en_r & ~(st_idle_stop_r & idle_mode);

  // Second and third stages must agree before a level counts
  // The first stage may go metastable, so only the second stage reads it
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      secondary_oscillator_s1_r  <= 1'b0;
      secondary_oscillator_s2_r  <= 1'b0;
      secondary_oscillator_s3_r  <= 1'b0;
      secondary_oscillator_lvl_r <= 1'b0;
    end else begin
      secondary_oscillator_s1_r <= secondary_oscillator_in;
      secondary_oscillator_s2_r <= secondary_oscillator_s1_r;
      secondary_oscillator_s3_r <= secondary_oscillator_s2_r;
      if (secondary_oscillator_s2_r == secondary_oscillator_s3_r) begin
        secondary_oscillator_lvl_r <= secondary_oscillator_s3_r;
      end
    end
  end

  // One pulse per slow rising edge; a glitch shorter than two cycles never counts
  assign secondary_oscillator_rise = secondary_oscillator_s3_r & secondary_oscillator_s2_r & ~secondary_oscillator_lvl_r;

  // Group several slow edges so one interval spans about 1 ms
  always @(posedge ref_clk) begin
    if (sys_rst || !loop_run) begin
      secondary_oscillator_edges_r <= 5'h00;
      secondary_oscillator_meas_r  <= 1'b0;
    end else begin
      secondary_oscillator_meas_r <= 1'b0;
      if (secondary_oscillator_rise) begin
        secondary_oscillator_edges_r <= secondary_oscillator_edges_r + 5'h01;
        secondary_oscillator_meas_r  <= (secondary_oscillator_edges_r == 5'h1F);
      end
    end
  end

  // One loop per reference; each knows its own expected count
  // The idle loop is held clear, so a reference change restarts by arming
  otr_tune_loop #(
    .EXP_CNT (USB_EXP_CNT)
  ) u_usb_loop (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .run       (loop_run & st_ref_r),
    .meas_evt  (sof_evt),
    .lock_r    (usb_lock),
    .oor_r     (usb_oor),
    .step_up_r (usb_up),
    .step_dn_r (usb_dn)
  );

  // Secondary reference: one interval per 32 filtered rising edges
  otr_tune_loop #(
    .EXP_CNT (SECONDARY_OSCILLATOR_EXP_CNT)
  ) u_secondary_oscillator_loop (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .run       (loop_run & ~st_ref_r),
    .meas_evt  (secondary_oscillator_meas_r),
    .lock_r    (secondary_oscillator_lock),
    .oor_r     (secondary_oscillator_oor),
    .step_up_r (secondary_oscillator_up),
    .step_dn_r (secondary_oscillator_dn)
  );

  // Reference select picks the live loop
  assign lock_st = st_ref_r ? usb_lock : secondary_oscillator_lock;
  assign oor_st  = st_ref_r ? usb_oor  : secondary_oscillator_oor;
  assign step_up = st_ref_r ? usb_up   : secondary_oscillator_up;
  assign step_dn = st_ref_r ? usb_dn   : secondary_oscillator_dn;

  // Tune control register; hardware owns the field while enabled
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      st_en_r        <= TUNE_RST_W[`OTR_ST_EN_BIT];
      st_idle_stop_r <= TUNE_RST_W[`OTR_ST_IDLE_BIT];
      st_ref_r       <= TUNE_RST_W[`OTR_ST_REF_BIT];
      lock_pol_r     <= TUNE_RST_W[`OTR_LOCK_POL_BIT];
      oor_pol_r      <= TUNE_RST_W[`OTR_OOR_POL_BIT];
      rc_tune_r      <= TUNE_RST_W[5:0];
    end else begin
      if (wr_tune) begin
        st_en_r        <= wdat[`OTR_ST_EN_BIT];
        st_idle_stop_r <= wdat[`OTR_ST_IDLE_BIT];
        st_ref_r       <= wdat[`OTR_ST_REF_BIT];
        lock_pol_r     <= wdat[`OTR_LOCK_POL_BIT];
        oor_pol_r      <= wdat[`OTR_OOR_POL_BIT];
      end
      if (st_en_r) begin
        // Saturate at the extreme codes instead of wrapping
        if (step_up && rc_tune_r != 6'h1F) begin
          rc_tune_r <= rc_tune_r + 6'h01;
        end else if (step_dn && rc_tune_r != 6'h20) begin
          rc_tune_r <= rc_tune_r - 6'h01;
        end
      end else if (wr_tune) begin
        // A write that turns enable on still loads the code sent with it
        rc_tune_r <= wdat[5:0];
      end
    end
  end

  // DIGITAL_CONTROLLED_OSC tune, DIGITAL_CONTROLLED_OSC control and divider registers
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      dco_tune_r <= 6'h00;
      dco_run_r  <= DCO_CTRL_W[`OTR_DCO_RUN_BIT];
      dco_fsel_r <= DCO_CTRL_W[`OTR_DCO_FSEL_LSB +: 4];
      div_r      <= DIV_RST_W;
    end else if (wr_en) begin
      case (sel)
        3'h1: begin
          dco_tune_r <= wdat[5:0];
        end
        3'h2: begin
          // Reserved select codes are stored as written
          dco_run_r  <= wdat[`OTR_DCO_RUN_BIT];
          dco_fsel_r <= wdat[11:8];
        end
        3'h3: begin
          div_r <= wdat[14:0];
        end
        default: begin
          // Tune control is handled above; nothing changes here
          div_r <= div_r;
        end
      endcase
    end
  end

  // Read images; unimplemented positions are held at zero
  assign tune_rd = {st_en_r, 1'b0, st_idle_stop_r, st_ref_r,
                    lock_st, lock_pol_r, oor_st, oor_pol_r,
                    2'b00, rc_tune_r} & (`OTR_TUNE_WMASK | 16'h0A00);
  assign dco_tune_rd = {10'h000, dco_tune_r};
  assign dco_ctrl_rd = {2'b00, dco_run_r, 1'b0, dco_fsel_r, 8'h00};
  assign div_rd      = {1'b0, div_r};

  // Read data is captured in the setup phase, stable in access
  // A write is seen by the next read only, never by a read in flight
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (sel)
        3'h0:    prdata <= {16'h0000, tune_rd};
        3'h1:    prdata <= {16'h0000, dco_tune_rd};
        3'h2:    prdata <= {16'h0000, dco_ctrl_rd};
        3'h3:    prdata <= {16'h0000, div_rd};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Status and oscillator control outputs, all registered
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      rc_tuning_field  <= 6'h00;
      lock_irq         <= 1'b0;
      oor_irq          <= 1'b0;
      dco_tuning_field <= 6'h00;
      dco_step_bp      <= `OTR_DCO_STEP_BP;
      dco_freq_mhz     <= 5'h08;
      dco_active       <= 1'b1;
    end else begin
      // Signed offset, the analog core decodes it about centre
      rc_tuning_field  <= rc_tune_r;
      // Interrupt lines are levels that follow status; nothing to clear
      lock_irq         <= (lock_st == ~lock_pol_r);
      oor_irq          <= (oor_st == ~oor_pol_r);
      dco_tuning_field <= dco_tune_r;
      // Top two settings use a coarser step per code
      dco_step_bp      <= (dco_fsel_r[3:1] == 3'h7) ?
                          `OTR_DCO_WIDE_BP : `OTR_DCO_STEP_BP;
      dco_freq_mhz     <= fsel_mhz(dco_fsel_r);
      // Sleep stops the oscillator unless software asked it to keep running
      dco_active       <= ~sleep_mode | dco_run_r;
    end
  end

  // Reference divider; its source is ref_clk itself
  // In bypass the output is a plain mux, so changing N to or from zero may glitch
  otr_clk_div u_div (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .half_period (div_r),
    .clk_out     (div_clk_out),
    .bypass      (div_bypass)
  );

endmodule

`default_nettype wire

/* File: src/otr_tune_loop.v */
/*
  Self-tune measurement loop: counts ref_clk cycles between reference
  events and reports lock, out-of-range and one-step adjust pulses.
  Assumes ref_clk is derived from the RC oscillator being tuned.
*/
`timescale 1ns/1ps
`default_nettype none
`include "otr_regs.vh"

module otr_tune_loop #(
  parameter [23:0] EXP_CNT = 24'd100000
) (
  input  wire ref_clk,
  input  wire sys_rst,
  input  wire run,
  input  wire meas_evt,
  output reg  lock_r,
  output reg  oor_r,
  output reg  step_up_r,
  output reg  step_dn_r
);

  // Tolerances are worked out wide, then cut to the counter width on purpose
  localparam [31:0] LOCK_TOL_W = EXP_CNT / `OTR_LOCK_DIV;
  localparam [31:0] OOR_TOL_W  = EXP_CNT * `OTR_OOR_NUM / `OTR_OOR_DEN;
  localparam [31:0] DEAD_TOL_W = EXP_CNT / `OTR_DEAD_DIV;
  localparam [23:0] LOCK_TOL   = LOCK_TOL_W[23:0];
  localparam [23:0] OOR_TOL    = OOR_TOL_W[23:0];
  localparam [23:0] DEAD_TOL   = DEAD_TOL_W[23:0];

  reg  [23:0] cnt_r;
  reg         armed_r;
  wire        fast;
  wire [23:0] err;

  assign fast = (cnt_r > EXP_CNT);
  assign err  = fast ? (cnt_r - EXP_CNT) : (EXP_CNT - cnt_r);

  // Each interval is judged once; adjust pulses last one cycle
  always @(posedge ref_clk) begin
    if (sys_rst || !run) begin
      cnt_r     <= 24'h00_0000;
      armed_r   <= 1'b0;
      lock_r    <= 1'b0;
      oor_r     <= 1'b0;
      step_up_r <= 1'b0;
      step_dn_r <= 1'b0;
    end else begin
      step_up_r <= 1'b0;
      step_dn_r <= 1'b0;
      if (meas_evt) begin
        cnt_r   <= 24'h00_0001;
        armed_r <= 1'b1;
        if (armed_r) begin
          lock_r <= (err <= LOCK_TOL);
          oor_r  <= (err > OOR_TOL);
          // No adjustment while out of range
          if (err <= OOR_TOL && err > DEAD_TOL) begin
            step_dn_r <= fast;
            step_up_r <= ~fast;
          end
        end
      end else if (cnt_r != 24'hFF_FFFF) begin
        cnt_r <= cnt_r + 24'h00_0001;
      end
    end
  end

endmodule

`default_nettype wire

/* File: tb/osc_tune_and_ref_divider_tb_top.sv */
/*
  Testbench for otr_top: APB register tests, DIGITAL_CONTROLLED_OSC decode, divider, self-tune.
  Assumes otr_regs.vh on the include path and the checker bound in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "otr_regs.vh"
module osc_tune_and_ref_divider_tb_top;
  logic        ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, v, perr;
  logic        idle_mode = 0, sleep_mode = 0, sof_evt = 0, secondary_oscillator_in = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, lock_irq, oor_irq, dco_active, div_clk_out, div_bypass;
  wire  [5:0]  rc, dco_tuning_field;
  wire  [4:0]  dco_step_bp, dco_freq_mhz;
  int          bad_count = 0, checks = 0, cyc = 0, sof_per = 1000, scnt = 0, sc = 0, n;

  // Short expected counts keep each tuning interval near 1000 cycles
  otr_top #(.USB_EXP_CNT(24'h00_03E8), .SECONDARY_OSCILLATOR_EXP_CNT(24'h00_03C0)) otr_top_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_mode(idle_mode), .sleep_mode(sleep_mode), .sof_evt(sof_evt), .secondary_oscillator_in(secondary_oscillator_in),
    .rc_tuning_field(rc), .lock_irq(lock_irq), .oor_irq(oor_irq),
    .dco_tuning_field(dco_tuning_field), .dco_step_bp(dco_step_bp),
    .dco_freq_mhz(dco_freq_mhz), .dco_active(dco_active), .div_clk_out(div_clk_out),
    .div_bypass(div_bypass));

  initial forever #5 ref_clk = ~ref_clk;

  // SOF pulse every sof_per cycles, SECONDARY_OSCILLATOR pin period 30 cycles, hang limit
  always @(posedge ref_clk) begin
    scnt <= (scnt >= sof_per - 1) ? 0 : scnt + 1;
    sof_evt <= (scnt == sof_per - 1);
    sc <= (sc == 14) ? 0 : sc + 1;
    if (sc == 14) secondary_oscillator_in <= ~secondary_oscillator_in;
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      bad_count++;
      stop_test;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  task automatic sofs(input int k);
    repeat (k) begin
      @(posedge ref_clk);
      while (sof_evt !== 1'b1) @(posedge ref_clk);
    end
    tick(4);
  endtask

  function automatic logic [31:0] mhz(input int f);
    return f < 8 ? f + 1 : f == 14 ? 15 : f == 15 ? 30 : 0;
  endfunction

  task stop_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    tick(2);
    sys_rst <= 1'b0;
    rchk(`OTR_ADDR_TUNE_CTRL, 32'h0000_1000);
    rchk(`OTR_ADDR_DCO_TUNE, 32'h0000_0000);
    rchk(`OTR_ADDR_DCO_CTRL, 32'h0000_0700);
    rchk(`OTR_ADDR_DIVISOR, 32'h0000_0001);
    chk(perr, 1'b0);
    rchk(12'h010, 32'h0000_0000);
    chk(perr, 1'b1);
    chk(dco_active, 1);
    // All-ones writes, except enable left clear in tune control: only writable bits stick
    apb(1'b1, `OTR_ADDR_TUNE_CTRL, 32'hFFFF_7FFF);
    rchk(`OTR_ADDR_TUNE_CTRL, 32'h0000_353F);
    chk({lock_irq, oor_irq, rc}, 8'hFF);
    apb(1'b1, `OTR_ADDR_DCO_TUNE, 32'hFFFF_FFFF);
    rchk(`OTR_ADDR_DCO_TUNE, 32'h0000_003F);
    chk(dco_tuning_field, 6'h3F);
    apb(1'b1, `OTR_ADDR_DIVISOR, 32'hFFFF_FFFF);
    rchk(`OTR_ADDR_DIVISOR, 32'h0000_7FFF);
    apb(1'b1, `OTR_ADDR_DIVISOR, 32'h0000_0000);
    @(negedge ref_clk);
    #1;
    chk({div_bypass, div_clk_out}, 2'b10);
    // Half period of three source clocks
    apb(1'b1, `OTR_ADDR_DIVISOR, 32'h0000_0003);
    tick(12);
    n = 0;
    v = div_clk_out;
    while (div_clk_out === v) @(negedge ref_clk);
    v = div_clk_out;
    while (div_clk_out === v) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n, 3);
    apb(1'b1, `OTR_ADDR_DIVISOR, 32'h0000_0001);
    // Every legal select code; reserved ones are never written
    for (int i = 0; i < 16; i++) begin
      if (i >= 8 && i <= 13) continue;
      apb(1'b1, `OTR_ADDR_DCO_CTRL, {20'h0_0000, i[3:0], 8'h00});
      tick(2);
      chk(dco_freq_mhz, mhz(i));
      chk(dco_step_bp, i >= 14 ? 29 : 15);
    end
    sleep_mode <= 1'b1;
    apb(1'b1, `OTR_ADDR_DCO_CTRL, 32'h0000_0700);
    tick(2);
    chk(dco_active, 0);
    apb(1'b1, `OTR_ADDR_DCO_CTRL, 32'h0000_2700);
    tick(2);
    chk(dco_active, 1);
    sleep_mode <= 1'b0;
    apb(1'b1, `OTR_ADDR_TUNE_CTRL, 32'h0000_1000);
    tick(3);
    chk({lock_irq, oor_irq, rc}, 8'h00);
    // Self-tune on SOF: lock, then one step per interval
    apb(1'b1, `OTR_ADDR_TUNE_CTRL, 32'h0000_9000);
    sofs(3);
    rchk(`OTR_ADDR_TUNE_CTRL, 32'h0000_9800);
    chk(lock_irq, 1);
    sof_per <= 1010;
    sofs(1);
    chk(rc, 6'h3F);
    sofs(1);
    chk(rc, 6'h3E);
    apb(1'b1, `OTR_ADDR_TUNE_CTRL, 32'h0000_9010);
    tick(2);
    chk(rc, 6'h3E);
    rchk(`OTR_ADDR_TUNE_CTRL, 32'h0000_903E);
    // Far outside the tuning span: status set, no step
    sof_per <= 1100;
    sofs(2);
    rchk(`OTR_ADDR_TUNE_CTRL, 32'h0000_923E);
    chk({oor_irq, rc}, 7'h7E);
    // Idle stop halts the loop
    idle_mode <= 1'b1;
    sof_per <= 1010;
    apb(1'b1, `OTR_ADDR_TUNE_CTRL, 32'h0000_B000);
    sofs(2);
    rchk(`OTR_ADDR_TUNE_CTRL, 32'h0000_B03E);
    // Climb to the top code and stay there
    idle_mode <= 1'b0;
    sof_per <= 990;
    sofs(40);
    chk(rc, 6'h1F);
    // Secondary oscillator reference
    apb(1'b1, `OTR_ADDR_TUNE_CTRL, 32'h0000_8000);
    tick(4000);
    rchk(`OTR_ADDR_TUNE_CTRL, 32'h0000_881F);
    stop_test;
  end
endmodule
`default_nettype wire

/* File: tb/otr_top_chk.sv */
/*
  Port-level checker for otr_top: shadows the writable fields from
  completed APB writes and checks outputs against them.
  Assumes ref_clk only, sys_rst synchronous active high, bound below.
*/
`timescale 1ns/1ps
`default_nettype none
`include "otr_regs.vh"
module otr_top_chk #(
  parameter [23:0] USB_EXP_CNT  = 24'h01_86A0,
  parameter [23:0] SECONDARY_OSCILLATOR_EXP_CNT = 24'h01_7D60
) (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        sleep_mode,
  input wire logic [5:0]  rc_tuning_field,
  input wire logic        lock_irq,
  input wire logic        oor_irq,
  input wire logic [4:0]  dco_step_bp,
  input wire logic [4:0]  dco_freq_mhz,
  input wire logic        dco_active,
  input wire logic        div_bypass
);
  logic [7:0]  quiet_r;
  logic        st_en_r, lpol_r, opol_r, run_r, swv_r;
  logic [3:0]  fsel_r;
  logic [5:0]  swt_r;
  logic [14:0] div_r;
  wire         wr = psel & penable & pwrite & pready;
  // Expected decode; reserved codes give 0
  wire [4:0]   mhz = (fsel_r < 4'h8) ? {1'b0, fsel_r} + 5'h01 :
                     (fsel_r == 4'hE) ? 5'h0F : (fsel_r == 4'hF) ? 5'h1E : 5'h00;

  // Shadow fields; quiet_r lets registered outputs settle after a write
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      quiet_r <= 8'h00;
      {st_en_r, lpol_r, opol_r, run_r, swv_r} <= 5'h01;
      fsel_r <= 4'h7;
      swt_r <= 6'h00;
      div_r <= 15'h0001;
    end else begin
      quiet_r <= wr ? 8'h00 : quiet_r + {7'h00, quiet_r != 8'hFF};
      if (wr && paddr == `OTR_ADDR_TUNE_CTRL) begin
        {st_en_r, lpol_r, opol_r} <= {pwdata[15], pwdata[10], pwdata[8]};
        swv_r <= !st_en_r && !pwdata[15];
        swt_r <= pwdata[5:0];
      end
      if (wr && paddr == `OTR_ADDR_DCO_CTRL)
        {run_r, fsel_r} <= {pwdata[13], pwdata[11:8]};
      if (wr && paddr == `OTR_ADDR_DIVISOR)
        div_r <= pwdata[14:0];
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_sw_tune_load: assert property (swv_r && quiet_r >= 8'h02 |-> rc_tuning_field == swt_r)
    else $error("rc tune code differs from software value");
  chk_tune_one_step: assert property (st_en_r && $past(st_en_r) && $past(st_en_r, 2) |->
    6'(rc_tuning_field - $past(rc_tuning_field)) inside {6'h00, 6'h01, 6'h3F} &&
    !($past(rc_tuning_field) == 6'h1F && rc_tuning_field == 6'h20) &&
    !($past(rc_tuning_field) == 6'h20 && rc_tuning_field == 6'h1F))
    else $error("rc tune code jumped or wrapped");
  chk_lock_irq_pol: assert property (!st_en_r && quiet_r >= 8'h03 |-> lock_irq == lpol_r)
    else $error("lock interrupt wrong for polarity");
  chk_oor_irq_pol: assert property (!st_en_r && quiet_r >= 8'h03 |-> oor_irq == opol_r)
    else $error("range interrupt wrong for polarity");
  chk_dco_sleep_run: assert property (quiet_r >= 8'h02 && $stable(sleep_mode) &&
    $past(sleep_mode) == $past(sleep_mode, 2) |-> dco_active == (!sleep_mode || run_r))
    else $error("dco active level wrong");
  chk_dco_freq_dec: assert property (quiet_r >= 8'h02 |-> dco_freq_mhz == mhz)
    else $error("dco frequency decode wrong");
  chk_dco_step_size: assert property (quiet_r >= 8'h02 |-> dco_step_bp ==
    (fsel_r >= 4'hE ? `OTR_DCO_WIDE_BP : `OTR_DCO_STEP_BP))
    else $error("dco step size wrong");
  chk_div_zero_pass: assert property (quiet_r >= 8'h02 |-> div_bypass == (div_r == 15'h0000))
    else $error("divider bypass wrong");
endmodule

bind otr_top otr_top_chk #(.USB_EXP_CNT(USB_EXP_CNT), .SECONDARY_OSCILLATOR_EXP_CNT(SECONDARY_OSCILLATOR_EXP_CNT)) otr_top_chk_i (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .sleep_mode(sleep_mode),
  .rc_tuning_field(rc_tuning_field), .lock_irq(lock_irq), .oor_irq(oor_irq),
  .dco_step_bp(dco_step_bp), .dco_freq_mhz(dco_freq_mhz), .dco_active(dco_active),
  .div_bypass(div_bypass));
`default_nettype wire
